/* File: acf_pkg.sv */
// Shared constants for the converter output format and mode control block
package acf_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Serial register addresses
	localparam logic [3:0]  ADDR_CONFIG       = 4'h1;
	localparam logic [3:0]  ADDR_OFFSET       = 4'h2;
	localparam logic [3:0]  ADDR_FULL_SCALE   = 4'h3;
	localparam logic [3:0]  ADDR_PHASE_FINE   = 4'hD;
	localparam logic [3:0]  ADDR_PHASE_COARSE = 4'hE;
	localparam logic [3:0]  ADDR_PATTERN      = 4'hF;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] RST_CONFIG        = 16'hB2DE;
	localparam logic [15:0] RST_OFFSET        = 16'h0000;
	localparam logic [15:0] RST_FULL_SCALE    = 16'h8000;
	localparam logic [15:0] RST_PHASE_FINE    = 16'h0000;
	localparam logic [15:0] RST_PHASE_COARSE  = 16'h0000;
	localparam logic [15:0] RST_PATTERN       = 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// Configuration register fields
	localparam int          CFG_DEMUX_2       = 0;
	localparam int          CFG_CONT_CLOCK    = 5;
	localparam int          CFG_SDR_EDGE      = 8;
	localparam int          CFG_SWING         = 9;
	localparam int          CFG_RATE_SDR      = 10;
	localparam int          CFG_DDR_PHASE     = 11;
	localparam int          CFG_DUTY_STAB     = 12;

	////////////////////////////////////////////////////////////////////////////
	// Serial frame layout
	localparam int          FRAME_BITS        = 32;
	localparam logic [11:0] FRAME_HEADER      = 12'h001;

	////////////////////////////////////////////////////////////////////////////
	// Manual calibration request qualification, input clock cycles
	localparam logic [6:0]  CAL_REQ_LOW_CYC   = 7'h50;
	localparam logic [6:0]  CAL_REQ_HIGH_CYC  = 7'h50;

	////////////////////////////////////////////////////////////////////////////
	// Calibration sequencer states
	typedef enum logic [3:0] {
		ST_POR_WAIT = 4'b0001,
		ST_ACTIVE   = 4'b0010,
		ST_CAL      = 4'b0100,
		ST_DOWN     = 4'b1000
	} acf_state_t;

endpackage : acf_pkg

/* File: acf_serial_rx.sv */
// Serial register write receiver on the serial clock domain
`timescale 1ns/1ps
`default_nettype none
module acf_serial_rx (
	input  wire logic        serial_clk,        // Serial clock from the controller
	input  wire logic        rst_n,             // Asynchronous reset, active low
	input  wire logic        serial_select_n,   // Frame select, active low
	input  wire logic        serial_input_line, // Serial data, MSB first
	output logic [3:0]       word_addr_q,       // Address of last good frame
	output logic [15:0]      word_data_q,       // Data of last good frame
	output logic             word_toggle_q      // Flips once per good frame
);

	logic [4:0]  bit_cnt_q;
	logic [30:0] shift_q;
	logic        frame_rst_n;
	logic [31:0] full_word;

	// Select high ends a frame even though the serial clock has stopped
	assign frame_rst_n = rst_n & ~serial_select_n;
	assign full_word   = {shift_q, serial_input_line};

	////////////////////////////////////////////////////////////////////////////
	// Bit counter wraps after 32 bits so frames run back to back
	always_ff @(posedge serial_clk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt_q <= 5'h00;
			shift_q   <= 31'h0000_0000;
		end else begin
			bit_cnt_q <= bit_cnt_q + 5'h01; // see R24
			shift_q   <= full_word[30:0];   // see R23
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Holding registers stay still for a whole frame, so the other domain
	// may read them once it has seen the toggle
	always_ff @(posedge serial_clk or negedge rst_n) begin
		if (!rst_n) begin
			word_addr_q   <= 4'h0;
			word_data_q   <= 16'h0000;
			word_toggle_q <= 1'b0;
		end else if (!serial_select_n && bit_cnt_q == 5'(acf_pkg::FRAME_BITS - 1)
				&& full_word[31:20] == acf_pkg::FRAME_HEADER) begin // see R23
			word_addr_q   <= full_word[19:16];
			word_data_q   <= full_word[15:0];
			word_toggle_q <= ~word_toggle_q;
		end
	end

endmodule : acf_serial_rx
`default_nettype wire

/* File: acf_output_format.sv */
// Output demultiplexer, output clocking, power-down and mode control
//
// Function
// R1: Default 1:4 demux on all four buses
// R2: Config bit 0 set selects 1:2 demux
// R3: 1:2 only in DDR, else outputs freeze
// R4: Bus A earliest sample, bus D latest
// R5: Falling-edge samples: D at 13, B at 14
// R6: Rising-edge samples: C at 13.5, A at 14.5
// R7: Normal mode adjusts sample phase automatically
// R8: SDR edge pin picks launch edge
// R9: SDR clock equals data rate, DDR half
// R10: Floating edge pin selects DDR in normal mode
// R11: Power-down tri-states outputs and stops activity
// R12: Power-down waits for running calibration
// R13: Power-down at power-up holds calibration delay
// R14: Manual calibration ignored while powered down
// R15: Controller keeps control mode fixed
// R16: Calibration delay pin only in normal mode
// R17: Extended full-scale set by register 3h
// R18: Extended offset set by register 2h
// R19: Extended phase set by Eh and Dh
// R20: Register Fh puts test pattern on outputs
// R21: Config bit 5 keeps output clock running
// R22: DDR phase fixed 0 unless extended bit
// R23: 32-bit frames: header, address, data, MSB first
// R24: Back-to-back frames without releasing select
// R25: Extended rate bit 10: 0 DDR, 1 SDR
// R26: In 1:2 mode buses A and B hold
`timescale 1ns/1ps
`default_nettype none
module acf_output_format #(
	parameter int unsigned LATENCY         = 13,           // Whole-cycle output latency
	parameter logic [31:0] SHORT_CAL_DELAY = 32'h0200_0000, // Power-up delay, short
	parameter logic [31:0] LONG_CAL_DELAY  = 32'h8000_0000, // Power-up delay, long
	parameter logic [31:0] CAL_RUN_CYCLES  = 32'h0000_1000  // Calibration length
) (
	input  wire logic        sys_clk,                 // Input sample clock
	input  wire logic        rst_n,                   // Asynchronous reset, active low
	input  wire logic        serial_clk,              // Serial interface clock
	input  wire logic        serial_select_n,         // Serial frame select, active low
	input  wire logic        serial_input_line,       // Serial data
	input  wire logic        powerdown_request,       // Power-down pin, high = down
	input  wire logic        range_or_extended_select,// Range pin level
	input  wire logic        range_pin_floating,      // Range pin floating = extended
	input  wire logic        sdr_launch_edge_pin,     // Edge pin level
	input  wire logic        edge_pin_floating,       // Edge pin floating = DDR
	input  wire logic        output_swing_pin,        // Output swing pin
	input  wire logic        cal_wait_select,         // Power-up delay select pin
	input  wire logic        cal_request_n,           // Manual calibration pin
	input  wire logic [7:0]  falling_edge_converter,  // Sample of falling-edge converter
	input  wire logic [7:0]  rising_edge_converter,   // Sample of rising-edge converter
	input  wire logic        fall_over_range,         // Over-range, falling-edge sample
	input  wire logic        rise_over_range,         // Over-range, rising-edge sample
	output logic [7:0]       bus_first_sample,        // Bus A
	output logic [7:0]       bus_second_sample,       // Bus B
	output logic [7:0]       bus_third_sample,        // Bus C
	output logic [7:0]       bus_fourth_sample,       // Bus D
	output logic             out_of_range,            // Over-range for current group
	output logic             forwarded_output_clock,  // Output data clock
	output logic             output_drive_en,         // High while outputs are driven
	output logic             cal_running,             // Calibration in progress
	output logic             extended_mode,           // Extended control active
	output logic             clock_phase_auto,        // Background phase tracking on
	output logic [15:0]      phase_coarse,            // Manual coarse phase
	output logic [15:0]      phase_fine,              // Manual fine phase
	output logic [15:0]      offset_code,             // Input offset setting
	output logic [15:0]      full_scale_code,         // Full-scale setting
	output logic             full_scale_high,         // Pin range choice, normal mode
	output logic             swing_bit,               // Output swing, high = normal
	output logic             duty_stabilizer_en       // Clock duty stabiliser on
);

	if (LATENCY < 2) begin : g_bad_latency
		$error("LATENCY must be at least 2");
	end
	if (CAL_RUN_CYCLES == 32'h0000_0000) begin : g_bad_cal_run
		$error("CAL_RUN_CYCLES must be nonzero");
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial receiver and crossing of its word toggle

	logic [3:0]  word_addr;
	logic [15:0] word_data;
	logic        word_toggle;
	logic [2:0]  tog_sync_q;
	logic        word_new;

	acf_serial_rx u_serial_rx (
		.serial_clk        (serial_clk),
		.rst_n             (rst_n),
		.serial_select_n   (serial_select_n),
		.serial_input_line (serial_input_line),
		.word_addr_q       (word_addr),
		.word_data_q       (word_data),
		.word_toggle_q     (word_toggle)
	);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tog_sync_q <= 3'h0;
		end else begin
			tog_sync_q <= {tog_sync_q[1:0], word_toggle};
		end
	end

	assign word_new = tog_sync_q[2] ^ tog_sync_q[1];

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [7:0] pin_meta_q;
	logic [7:0] pin_q;
	logic       pd_s;
	logic       range_s;
	logic       range_float_s;
	logic       edge_s;
	logic       edge_float_s;
	logic       swing_s;
	logic       wait_long_s;
	logic       cal_req_n_s;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= 8'h80;
			pin_q      <= 8'h80;
		end else begin
			pin_meta_q <= {cal_request_n, cal_wait_select, output_swing_pin, edge_pin_floating,
				sdr_launch_edge_pin, range_pin_floating, range_or_extended_select, powerdown_request};
			pin_q      <= pin_meta_q;
		end
	end

	assign {cal_req_n_s, wait_long_s, swing_s, edge_float_s, edge_s, range_float_s, range_s, pd_s} = pin_q;

	////////////////////////////////////////////////////////////////////////////
	// Control mode is sampled on the first three cycles after reset and then held

	logic [1:0] mode_cnt_q;
	logic       ext_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_cnt_q <= 2'h0;
			ext_q      <= 1'b0;
		end else if (mode_cnt_q != 2'h3) begin
			mode_cnt_q <= mode_cnt_q + 2'h1;
			ext_q      <= range_float_s; // see R15
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Extended registers, written only in extended mode

	logic [15:0] cfg_q;
	logic [15:0] offset_q;
	logic [15:0] fs_q;
	logic [15:0] fine_q;
	logic [15:0] coarse_q;
	logic [15:0] pat_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q    <= acf_pkg::RST_CONFIG;
			offset_q <= acf_pkg::RST_OFFSET;
			fs_q     <= acf_pkg::RST_FULL_SCALE;
			fine_q   <= acf_pkg::RST_PHASE_FINE;
			coarse_q <= acf_pkg::RST_PHASE_COARSE;
			pat_q    <= acf_pkg::RST_PATTERN;
		end else if (word_new && ext_q) begin
			unique case (word_addr)
				acf_pkg::ADDR_CONFIG:       cfg_q    <= word_data;
				acf_pkg::ADDR_OFFSET:       offset_q <= word_data; // see R18
				acf_pkg::ADDR_FULL_SCALE:   fs_q     <= word_data; // see R17
				acf_pkg::ADDR_PHASE_FINE:   fine_q   <= word_data; // see R19
				acf_pkg::ADDR_PHASE_COARSE: coarse_q <= word_data; // see R19
				acf_pkg::ADDR_PATTERN:      pat_q    <= word_data; // see R20
				default: ;
			endcase
		end
	end

	// Register effects only reach the outputs in extended mode
	assign extended_mode      = ext_q;
	assign clock_phase_auto   = ~ext_q;                                        // see R7
	assign phase_coarse       = ext_q ? coarse_q : acf_pkg::RST_PHASE_COARSE;  // see R19
	assign phase_fine         = ext_q ? fine_q : acf_pkg::RST_PHASE_FINE;      // see R19
	assign offset_code        = ext_q ? offset_q : acf_pkg::RST_OFFSET;        // see R18
	assign full_scale_code    = ext_q ? fs_q : acf_pkg::RST_FULL_SCALE;        // see R17
	assign full_scale_high    = ~ext_q & range_s;
	assign swing_bit          = ext_q ? cfg_q[acf_pkg::CFG_SWING] : swing_s;
	assign duty_stabilizer_en = ext_q ? cfg_q[acf_pkg::CFG_DUTY_STAB] : 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// Manual calibration request: 80 cycles low then 80 cycles high

	acf_pkg::acf_state_t st_q;
	logic [6:0]  req_low_q;
	logic [6:0]  req_high_q;
	logic        req_armed_q;
	logic        cal_req_pulse;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_low_q   <= 7'h00;
			req_high_q  <= 7'h00;
			req_armed_q <= 1'b0;
		end else if (st_q != acf_pkg::ST_ACTIVE) begin
			// Requests seen while down are dropped, not remembered
			req_low_q   <= 7'h00; // see R14
			req_high_q  <= 7'h00;
			req_armed_q <= 1'b0;
		end else if (!cal_req_n_s) begin
			req_high_q  <= 7'h00;
			if (req_low_q == acf_pkg::CAL_REQ_LOW_CYC - 7'h01) begin
				req_armed_q <= 1'b1;
			end else begin
				req_low_q <= req_low_q + 7'h01;
			end
		end else begin
			req_low_q <= 7'h00;
			if (cal_req_pulse) begin
				req_armed_q <= 1'b0;
				req_high_q  <= 7'h00;
			end else if (req_armed_q) begin
				req_high_q <= req_high_q + 7'h01;
			end
		end
	end

	assign cal_req_pulse = req_armed_q && cal_req_n_s && req_high_q == acf_pkg::CAL_REQ_HIGH_CYC - 7'h01;

	////////////////////////////////////////////////////////////////////////////
	// Calibration and power-down sequencer

	logic [31:0] seq_cnt_q;
	logic [31:0] por_delay;

	assign por_delay = (!ext_q && wait_long_s) ? LONG_CAL_DELAY : SHORT_CAL_DELAY; // see R16

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q      <= acf_pkg::ST_POR_WAIT;
			seq_cnt_q <= 32'h0000_0000;
		end else begin
			unique case (st_q)
				acf_pkg::ST_POR_WAIT: begin
					if (!pd_s) begin // see R13
						if (seq_cnt_q >= por_delay - 32'h0000_0001) begin
							st_q      <= acf_pkg::ST_CAL;
							seq_cnt_q <= 32'h0000_0000;
						end else begin
							seq_cnt_q <= seq_cnt_q + 32'h0000_0001;
						end
					end
				end
				acf_pkg::ST_ACTIVE: begin
					if (pd_s) begin
						st_q <= acf_pkg::ST_DOWN; // see R11
					end else if (cal_req_pulse) begin
						st_q      <= acf_pkg::ST_CAL;
						seq_cnt_q <= 32'h0000_0000;
					end
				end
				acf_pkg::ST_CAL: begin
					if (seq_cnt_q == CAL_RUN_CYCLES - 32'h0000_0001) begin
						st_q      <= pd_s ? acf_pkg::ST_DOWN : acf_pkg::ST_ACTIVE; // see R12
						seq_cnt_q <= 32'h0000_0000;
					end else begin
						seq_cnt_q <= seq_cnt_q + 32'h0000_0001;
					end
				end
				acf_pkg::ST_DOWN: begin
					if (!pd_s) begin
						st_q <= acf_pkg::ST_ACTIVE;
					end
				end
			endcase
		end
	end

	assign cal_running = (st_q == acf_pkg::ST_CAL);

	////////////////////////////////////////////////////////////////////////////
	// Output mode decode

	logic ddr;
	logic sdr_rise;
	logic phase90;
	logic demux2;
	logic frozen;
	logic pattern_on;
	logic stopped;
	logic forwarded_output_clock_run;

	assign ddr        = ext_q ? ~cfg_q[acf_pkg::CFG_RATE_SDR] : edge_float_s;     // see R25 see R10
	assign sdr_rise   = ext_q ? cfg_q[acf_pkg::CFG_SDR_EDGE] : edge_s;            // see R8
	assign phase90    = ext_q & cfg_q[acf_pkg::CFG_DDR_PHASE];                    // see R22
	assign demux2     = ext_q & cfg_q[acf_pkg::CFG_DEMUX_2];                      // see R2
	assign frozen     = demux2 & ~ddr;                                            // see R3
	assign pattern_on = ext_q & (pat_q != 16'h0000);                              // see R20
	assign stopped    = (st_q == acf_pkg::ST_DOWN) || (st_q == acf_pkg::ST_POR_WAIT && pd_s);
	// Without the continuous bit the clock pauses through calibration
	assign forwarded_output_clock_run   = (st_q == acf_pkg::ST_ACTIVE) ||
		(!stopped && ext_q && cfg_q[acf_pkg::CFG_CONT_CLOCK]);                    // see R21

	////////////////////////////////////////////////////////////////////////////
	// Sample delay lines, one entry per input clock

	logic [8:0] fall_pipe_q [0:LATENCY];
	logic [8:0] rise_pipe_q [0:LATENCY];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fall_pipe_q[0] <= 9'h000;
			rise_pipe_q[0] <= 9'h000;
		end else begin
			fall_pipe_q[0] <= {fall_over_range, falling_edge_converter};
			rise_pipe_q[0] <= {rise_over_range, rising_edge_converter};
		end
	end

	for (genvar g = 1; g <= LATENCY; g++) begin : g_pipe
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				fall_pipe_q[g] <= 9'h000;
				rise_pipe_q[g] <= 9'h000;
			end else begin
				fall_pipe_q[g] <= fall_pipe_q[g-1];
				rise_pipe_q[g] <= rise_pipe_q[g-1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output word registers

	logic       phase_q;
	logic       slot;
	logic       update;
	logic [7:0] pat_cnt_q;
	logic [7:0] bus_a_q;
	logic [7:0] bus_b_q;
	logic [7:0] bus_c_q;
	logic [7:0] bus_d_q;
	logic       oor_q;

	// In 1:4 a group leaves every second input clock, in 1:2 every clock
	assign slot   = demux2 | phase_q;                 // see R1
	assign update = slot & ~frozen & ~stopped;        // see R3 see R11

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= 1'b0;
		end else if (!stopped) begin
			phase_q <= ~phase_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_a_q   <= 8'h00;
			bus_b_q   <= 8'h00;
			bus_c_q   <= 8'h00;
			bus_d_q   <= 8'h00;
			oor_q     <= 1'b0;
			pat_cnt_q <= 8'h00;
		end else if (update) begin
			if (pattern_on) begin
				bus_a_q   <= pat_cnt_q;
				bus_b_q   <= pat_cnt_q + 8'h01;
				bus_c_q   <= pat_cnt_q + 8'h02;
				bus_d_q   <= pat_cnt_q + 8'h03;
				oor_q     <= 1'b0;
				pat_cnt_q <= pat_cnt_q + 8'h04;
			end else if (demux2) begin
				// Buses A and B keep their last word
				bus_c_q <= rise_pipe_q[LATENCY-1][7:0]; // see R26 see R6
				bus_d_q <= fall_pipe_q[LATENCY-1][7:0]; // see R5
				oor_q   <= rise_pipe_q[LATENCY-1][8] | fall_pipe_q[LATENCY-1][8];
			end else begin
				bus_a_q <= rise_pipe_q[LATENCY][7:0]; // see R4 see R6
				bus_b_q <= fall_pipe_q[LATENCY][7:0]; // see R5
				bus_c_q <= rise_pipe_q[LATENCY-1][7:0]; // see R6
				bus_d_q <= fall_pipe_q[LATENCY-1][7:0]; // see R4 see R5
				oor_q   <= rise_pipe_q[LATENCY][8] | fall_pipe_q[LATENCY][8] |
					rise_pipe_q[LATENCY-1][8] | fall_pipe_q[LATENCY-1][8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output clock

	logic forwarded_output_clock_q;
	logic drive_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			forwarded_output_clock_q <= 1'b0;
		end else if (stopped) begin
			forwarded_output_clock_q <= 1'b0;                        // see R11
		end else if (forwarded_output_clock_run) begin
			if (ddr) begin
				// Half-rate clock; 90 degrees only fits the two-clock cell of 1:4
				if (demux2 || (slot ^ phase90)) begin // see R9 see R22
					forwarded_output_clock_q <= ~forwarded_output_clock_q;
				end
			end else begin
				forwarded_output_clock_q <= slot ? sdr_rise : ~sdr_rise; // see R8 see R9
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_q <= 1'b0;
		end else begin
			drive_q <= ~stopped; // see R11
		end
	end

	assign bus_first_sample       = bus_a_q;
	assign bus_second_sample      = bus_b_q;
	assign bus_third_sample       = bus_c_q;
	assign bus_fourth_sample      = bus_d_q;
	assign out_of_range           = oor_q;
	assign forwarded_output_clock = forwarded_output_clock_q;
	assign output_drive_en        = drive_q;

endmodule : acf_output_format
`default_nettype wire

/* File: acf_output_format_sva.sv */
// Checker: sample order, latency, output clocking, power-down
`timescale 1ns/1ps
`default_nettype none
module acf_output_format_sva (
	input wire logic       sys_clk,                // Clock
	input wire logic       rst_n,                  // Reset
	input wire logic       powerdown_request,      // Down pin
	input wire logic       edge_pin_floating,      // DDR pin
	input wire logic       sdr_launch_edge_pin,    // Edge pin
	input wire logic [7:0] falling_edge_converter, // Fall sample
	input wire logic [7:0] rising_edge_converter,  // Rise sample
	input wire logic [7:0] bus_first_sample,       // Bus A
	input wire logic [7:0] bus_second_sample,      // Bus B
	input wire logic [7:0] bus_third_sample,       // Bus C
	input wire logic [7:0] bus_fourth_sample,      // Bus D
	input wire logic       forwarded_output_clock, // Out clock
	input wire logic       output_drive_en,        // Driving
	input wire logic       cal_running,            // Calibrating
	input wire logic       extended_mode           // Register mode
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Pin-controlled clocking, judged only while running
	wire logic run = output_drive_en && !cal_running && !extended_mode;
	wire logic ddr = run && edge_pin_floating;
	wire logic sdr = run && !edge_pin_floating;
	lat_d_a: assert property ($changed(bus_fourth_sample) |->
		bus_fourth_sample == $past(falling_edge_converter, 14)) else $error("bus D latency");
	lat_c_a: assert property ($changed(bus_third_sample) |->
		bus_third_sample == $past(rising_edge_converter, 14)) else $error("bus C latency");
	lat_a_a: assert property ($changed(bus_first_sample) |->
		bus_first_sample == $past(rising_edge_converter, 15)) else $error("bus A latency");
	lat_b_a: assert property ($changed(bus_second_sample) |->
		bus_second_sample == $past(falling_edge_converter, 15)) else $error("bus B latency");
	pd_off_a: assert property ((powerdown_request && !cal_running) [*6] |->
		!output_drive_en) else $error("not tristated");
	cal_hold_a: assert property (cal_running && $past(cal_running) |->
		output_drive_en) else $error("down during cal");
	ddr_clk_a: assert property (ddr && $changed(forwarded_output_clock) |=>
		$stable(forwarded_output_clock)) else $error("ddr clock rate");
	ddr_ph_a: assert property (ddr && $changed(forwarded_output_clock) |->
		$changed(bus_fourth_sample)) else $error("ddr phase");
	sdr_edge_a: assert property (sdr && $changed(forwarded_output_clock) |->
		$changed(bus_fourth_sample) == (forwarded_output_clock == sdr_launch_edge_pin))
		else $error("sdr launch edge");
	cover property ($fell(cal_running));
	cover property (ddr && $changed(forwarded_output_clock));
	cover property ($fell(output_drive_en));
endmodule : acf_output_format_sva
bind acf_output_format acf_output_format_sva acf_output_format_sva_i (.*);
`default_nettype wire

/* File: acf_receiver_model.sv */
// Receiving logic: latches bus D on both forwarded clock edges
`timescale 1ns/1ps
`default_nettype none
module acf_receiver_model (
	input wire logic       fwd_clk,  // Forwarded clock
	input wire logic       drive_en, // Outputs driven
	input wire logic [7:0] bus_d,    // Latest bus
	output int             captures  // Words taken
);
	logic [7:0] word_q;
	initial captures = 0;
	always @(fwd_clk) if (drive_en) begin
		word_q <= bus_d;
		captures <= captures + 1;
	end
endmodule : acf_receiver_model
`default_nettype wire

/* File: acf_output_format_tb.sv */
// Bench: pin and register scenarios for the output format block
`timescale 1ns/1ps
`default_nettype none
module acf_output_format_tb;
	localparam logic [11:0] HD = acf_pkg::FRAME_HEADER;
	logic        sys_clk = 0, rst_n = 0, sclk = 0, sel_n = 1, sdi = 0, pd = 0;
	logic        rpf = 0, epf = 1, edg = 0, cwt = 0, cal_n = 1, f_or = 0, r_or = 0;
	logic [7:0]  fs = 0, rs = 0, ba, bd;
	logic [15:0] off, fsc, phf, phc;
	logic        fclk, den, calr, pauto;
	int          rx_n, n, bad_count = 0, n_checks = 0;
	acf_output_format #(.SHORT_CAL_DELAY(32'h14), .LONG_CAL_DELAY(32'h28), .CAL_RUN_CYCLES(32'h10))
	acf_output_format_i (.sys_clk(sys_clk), .rst_n(rst_n), .serial_clk(sclk), .serial_select_n(sel_n),
		.serial_input_line(sdi), .powerdown_request(pd), .range_or_extended_select(1'b0), .range_pin_floating(rpf),
		.sdr_launch_edge_pin(edg), .edge_pin_floating(epf), .output_swing_pin(1'b1), .cal_wait_select(cwt),
		.cal_request_n(cal_n), .falling_edge_converter(fs), .rising_edge_converter(rs), .fall_over_range(f_or),
		.rise_over_range(r_or), .bus_first_sample(ba), .bus_second_sample(), .bus_third_sample(),
		.bus_fourth_sample(bd), .out_of_range(), .forwarded_output_clock(fclk), .output_drive_en(den),
		.cal_running(calr), .extended_mode(), .clock_phase_auto(pauto), .phase_coarse(phc), .phase_fine(phf),
		.offset_code(off), .full_scale_code(fsc), .full_scale_high(), .swing_bit(), .duty_stabilizer_en());
	acf_receiver_model acf_receiver_model_i (.fwd_clk(fclk), .drive_en(den), .bus_d(bd), .captures(rx_n));
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		fs <= fs + 8'h01;
		rs <= fs + 8'h81;
		f_or <= fs[3];
		r_or <= fs[4];
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic chb(string nm, logic seen, logic exp);
		chk(nm, {15'h0000, seen}, {15'h0000, exp});
	endtask : chb
	task automatic cyc(int k);
		repeat (k) @(posedge sys_clk);
	endtask : cyc
	// Range, wait and edge pins move only inside reset: the control mode stays fixed while running
	task automatic restart(logic f, logic e, logic p, logic d);
		cyc(1);
		rst_n <= 0;
		rpf <= f;
		cwt <= f;
		epf <= e;
		edg <= p;
		pd <= d;
		cyc(6);
		rst_n <= 1;
	endtask : restart
	task automatic wait_cal(logic d);
		for (n = 0; n < 32 && calr !== 1'b1; n++)
			@(negedge sys_clk);
		chb("cal_start", calr, 1);
		cyc(1);
		pd <= d;
		repeat (6) @(negedge sys_clk);
		chb("drive_in_cal", den, 1);
		for (n = 0; n < 40 && calr !== 1'b0; n++)
			@(negedge sys_clk);
		cyc(1);
	endtask : wait_cal
	task automatic tog(logic [15:0] ec, logic [15:0] ed, logic [15:0] ea);
		logic       c;
		logic [7:0] d, a;
		int         nc = 0, nd = 0, na = 0;
		@(negedge sys_clk);
		{c, d, a} = {fclk, bd, ba};
		repeat (8) begin
			@(negedge sys_clk);
			nc += int'(fclk !== c);
			nd += int'(bd !== d);
			na += int'(ba !== a);
			{c, d, a} = {fclk, bd, ba};
		end
		chk("clk_moves", nc[15:0], ec);
		chk("d_moves", nd[15:0], ed);
		chk("a_moves", na[15:0], ea);
	endtask : tog
	// Serial clock runs only inside frames
	task automatic wr(logic [31:0] w, logic rel);
		#3 sel_n = 0;
		for (int b = 31; b >= 0; b--) begin
			sdi = w[b];
			#8 sclk = 1;
			#16 sclk = 0;
			#8;
		end
		sdi = ~w[0];
		sel_n = rel;
	endtask : wr
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	initial begin
		#400000;
		bad_count++;
		report_and_stop();
	end
	initial begin
		restart(0, 1, 0, 0);
		wait_cal(0);
		tog(4, 4, 4);
		chb("auto_phase", pauto, 1);
		chk("offset_fixed", off, acf_pkg::RST_OFFSET);
		chb("rx_capture", rx_n > 0, 1);
		for (int e = 0; e < 2; e++) begin
			restart(0, 0, e[0], 0);
			wait_cal(0);
			tog(8, 4, 4);
		end
		restart(1, 0, 0, 0);
		wait_cal(0);
		wr({HD, acf_pkg::ADDR_OFFSET, 16'h0123}, 0);
		wr({HD, acf_pkg::ADDR_FULL_SCALE, 16'h01FF}, 0);
		wr({HD, acf_pkg::ADDR_PHASE_FINE, 16'h00A5}, 0);
		wr({HD, acf_pkg::ADDR_PHASE_COARSE, 16'h005A}, 0);
		wr({12'h003, acf_pkg::ADDR_OFFSET, 16'h5555}, 0);
		wr({HD, 4'h4, 16'hFFFF}, 1);
		cyc(8);
		@(negedge sys_clk);
		chk("offset", off, 16'h0123);
		chk("full_scale", fsc, 16'h01FF);
		chk("fine", phf, 16'h00A5);
		chk("coarse", phc, 16'h005A);
		chb("manual_phase", pauto, 0);
		wr({HD, acf_pkg::ADDR_CONFIG, 16'hB2DF}, 1);
		cyc(8);
		tog(8, 8, 0);
		wr({HD, acf_pkg::ADDR_CONFIG, 16'hB6DF}, 1);
		cyc(8);
		tog(0, 0, 0);
		wr({HD, acf_pkg::ADDR_CONFIG, 16'hB6DE}, 1);
		cyc(8);
		tog(8, 4, 4);
		restart(0, 0, 1, 1);
		cyc(60);
		@(negedge sys_clk);
		chb("cal_held", calr, 0);
		chb("tristate", den, 0);
		cyc(1);
		pd <= 0;
		wait_cal(0);
		cal_n <= 0;
		cyc(85);
		cal_n <= 1;
		cyc(85);
		wait_cal(1);
		cyc(8);
		tog(0, 0, 0);
		chb("tristate", den, 0);
		cyc(1);
		cal_n <= 0;
		cyc(85);
		cal_n <= 1;
		cyc(85);
		pd <= 0;
		n = 0;
		repeat (40) begin
			@(negedge sys_clk);
			n += int'(calr);
		end
		chk("no_cal", n[15:0], 16'h0000);
		report_and_stop();
	end
endmodule : acf_output_format_tb
`default_nettype wire
